// *** inc/xbs_pkg.sv ***
// Package of constants and carrier types for the crossbar switch with bridges.
package xbs_pkg;

	// ----------------------------------------
	// Sizes and indices
	// ----------------------------------------
	localparam int NM = 5;
	localparam int NT = 5;
	localparam int M_CPU_DATA = 0;
	localparam int M_PROG_FILL = 1;
	localparam int M_DMA_HIGH = 2;
	localparam int M_DMA_LOW = 3;
	localparam int M_HOST = 4;
	localparam int T_ONCHIP_MEM = 0;
	localparam int T_EXT_MEM = 1;
	localparam int T_PERIPH_CFG = 2;
	localparam int T_AUDIO_DMA = 3;
	localparam int T_DMA_REGS = 4;

	// ----------------------------------------
	// Address map, decoded on the top address byte, or on the top nibble for external memory
	// ----------------------------------------
	localparam logic [7:0] ROM_TOP_BYTE = 8'h00;
	localparam logic [7:0] RAM_TOP_BYTE = 8'h10;
	localparam logic [7:0] PERIPH_FIRST_BYTE = 8'h40;
	localparam logic [7:0] PERIPH_LAST_BYTE = 8'h4A;
	localparam logic [7:0] AUDIO_FIRST_BYTE = 8'h54;
	localparam logic [7:0] AUDIO_LAST_BYTE = 8'h56;
	localparam logic [7:0] DMAREG_FIRST_BYTE = 8'h60;
	localparam logic [7:0] DMAREG_LAST_BYTE = 8'h62;
	localparam logic [3:0] EXT_SDRAM_NIBBLE = 4'h8;
	localparam logic [3:0] EXT_ASYNC_NIBBLE = 4'h9;

	// ----------------------------------------
	// Bridge control register
	// ----------------------------------------
	localparam logic [31:0] BRIDGE_CONTROL_ADDR = 32'h4000_0024;
	localparam int SLAVE_BRIDGE_RESET_BIT = 0;
	localparam logic SLAVE_BRIDGE_RESET_RST = 1'b1;

	// ----------------------------------------
	// Bridge timing and priority
	// ----------------------------------------
	localparam int BRIDGE_STAGE_CYCLES = 2;
	localparam logic [2:0] RANK_LAST = 3'h5;
	localparam logic [1:0] HOPS_NO_ROUTE = 2'h3;
	localparam logic [14:0] DEFAULT_RANKS = {3'h4, 3'h3, 3'h2, 3'h1, 3'h0};

	// ----------------------------------------
	// Carrier types
	// ----------------------------------------
	typedef struct packed {
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [31:0] adr;
		logic [31:0] dat;
	} xbs_req_t;

	typedef struct packed {
		logic ack;
		logic err;
		logic [31:0] dat;
	} xbs_rsp_t;

endpackage

// *** hw/xbs_crossbar.sv ***
// Crossbar switch joining five masters to five target groups through bridge stages.
`timescale 1ns/1ps
//
// Notes on behaviour
// [RQ1] Accept requests from five masters.
// [RQ2] Route requests to five target groups.
// [RQ3] Different targets serve different masters concurrently.
// [RQ4] Same-cycle contention: highest priority wins, others stall.
// [RQ5] Owner finishes whole access before rearbitration.
// [RQ6] High-priority DMA beats low-priority DMA.
// [RQ7] Program port ranks fifth at external memory, one bridge.
// [RQ8] Cross-rate paths pass through a buffering bridge.
// [RQ9] Data bridge serves peripherals, DMA registers, external memory.
// [RQ10] Memory bridge carries DMA and host to on-chip memory.
// [RQ11] Two bridges feed external memory from both sides.
// [RQ12] Bit 0 holds memory bridge in reset, resets 1.
// [RQ13] Software pulses bridge reset after clock changes.
// [RQ14] Software writes zeros to reserved bits.
// [RQ15] Master priority order is a design parameter.
// [RQ16] Stalled master keeps request pending until granted.
module xbs_crossbar #(
	parameter logic [14:0] MASTER_RANK = xbs_pkg::DEFAULT_RANKS,
	parameter int BRIDGE_LAT = xbs_pkg::BRIDGE_STAGE_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire xbs_pkg::xbs_req_t i_m_req [xbs_pkg::NM],
	output xbs_pkg::xbs_rsp_t o_m_rsp [xbs_pkg::NM],
	output xbs_pkg::xbs_req_t o_t_req [xbs_pkg::NT],
	input wire xbs_pkg::xbs_rsp_t i_t_rsp [xbs_pkg::NT],
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [31:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	output logic o_slave_bridge_reset
);

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (MASTER_RANK[3*xbs_pkg::M_DMA_HIGH +: 3] >= MASTER_RANK[3*xbs_pkg::M_DMA_LOW +: 3]) begin : g_bad_rank
		$error("High-priority DMA port must outrank the low-priority DMA port.");
	end
	if (BRIDGE_LAT < 1 || BRIDGE_LAT > 3) begin : g_bad_lat
		$error("BRIDGE_LAT must lie between 1 and 3.");
	end

	typedef enum logic [1:0] {XBS_IDLE, XBS_CROSS, XBS_ISSUE, XBS_DONE} xbs_tstate_t;

	// ----------------------------------------
	// Decode and routing functions
	// ----------------------------------------
	// Returns the target group of an address, or NT when nothing is mapped there.
	function automatic logic [2:0] decode_target(input logic [31:0] adr);
		logic [7:0] top;
		top = adr[31:24];
		if (top == xbs_pkg::ROM_TOP_BYTE || top == xbs_pkg::RAM_TOP_BYTE)
			return 3'(xbs_pkg::T_ONCHIP_MEM);
		else if (adr[31:28] == xbs_pkg::EXT_SDRAM_NIBBLE || adr[31:28] == xbs_pkg::EXT_ASYNC_NIBBLE)
			return 3'(xbs_pkg::T_EXT_MEM);
		else if (top >= xbs_pkg::PERIPH_FIRST_BYTE && top <= xbs_pkg::PERIPH_LAST_BYTE)
			return 3'(xbs_pkg::T_PERIPH_CFG);
		else if (top >= xbs_pkg::AUDIO_FIRST_BYTE && top <= xbs_pkg::AUDIO_LAST_BYTE)
			return 3'(xbs_pkg::T_AUDIO_DMA);
		else if (top >= xbs_pkg::DMAREG_FIRST_BYTE && top <= xbs_pkg::DMAREG_LAST_BYTE)
			return 3'(xbs_pkg::T_DMA_REGS);
		return 3'(xbs_pkg::NT);
	endfunction

	// Number of bridge crossings between a master and a target; no route when a
	// master has no path to that target in the switch.
	function automatic logic [1:0] bridge_hops(input int m, input int t);
		logic [1:0] h;
		h = xbs_pkg::HOPS_NO_ROUTE;
		if (m == xbs_pkg::M_CPU_DATA) begin
			if (t == xbs_pkg::T_EXT_MEM)
				h = 2'h2; // [RQ9] [RQ11]
			else if (t != xbs_pkg::T_ONCHIP_MEM)
				h = 2'h1; // [RQ9]
		end else if (m == xbs_pkg::M_PROG_FILL) begin
			if (t == xbs_pkg::T_EXT_MEM)
				h = 2'h1; // [RQ7] [RQ11]
		end else begin
			if (t == xbs_pkg::T_ONCHIP_MEM || t == xbs_pkg::T_EXT_MEM)
				h = 2'h1; // [RQ10] [RQ11]
			else
				h = 2'h0;
		end
		return h;
	endfunction

	// Rank used at a target; lower wins.
	function automatic logic [2:0] rank_at(input int m, input int t);
		if (m == xbs_pkg::M_PROG_FILL && t == xbs_pkg::T_EXT_MEM)
			return xbs_pkg::RANK_LAST; // [RQ7]
		return MASTER_RANK[3*m +: 3]; // [RQ15]
	endfunction

	// ----------------------------------------
	// Bridge control register over Wishbone
	// ----------------------------------------
	logic slave_bridge_reset_r;
	logic wb_hit;

	assign wb_hit = i_wb_adr == xbs_pkg::BRIDGE_CONTROL_ADDR;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0000_0000;
		end else begin
			o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
			o_wb_dat <= 32'h0000_0000;
			if (wb_hit)
				o_wb_dat[xbs_pkg::SLAVE_BRIDGE_RESET_BIT] <= slave_bridge_reset_r;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			slave_bridge_reset_r <= xbs_pkg::SLAVE_BRIDGE_RESET_RST; // [RQ12]
		end else if (i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack && wb_hit && i_wb_sel[0]) begin
			slave_bridge_reset_r <= i_wb_dat[xbs_pkg::SLAVE_BRIDGE_RESET_BIT]; // [RQ12]
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst)
			o_slave_bridge_reset <= xbs_pkg::SLAVE_BRIDGE_RESET_RST;
		else
			o_slave_bridge_reset <= slave_bridge_reset_r;
	end

	// ----------------------------------------
	// Per-master decode
	// ----------------------------------------
	logic [2:0] m_target [xbs_pkg::NM];
	logic m_unroutable [xbs_pkg::NM];

	for (genvar gm = 0; gm < xbs_pkg::NM; gm++) begin : g_mdec
		assign m_target[gm] = decode_target(i_m_req[gm].adr); // [RQ1]
		always_comb begin
			m_unroutable[gm] = 1'b1;
			for (int t = 0; t < xbs_pkg::NT; t++) begin
				if (m_target[gm] == 3'(t) && bridge_hops(gm, t) != xbs_pkg::HOPS_NO_ROUTE)
					m_unroutable[gm] = 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Per-target arbiter and bridge stage
	// ----------------------------------------
	xbs_tstate_t t_state_r [xbs_pkg::NT];
	logic [2:0] t_owner_r [xbs_pkg::NT];
	logic [2:0] t_cnt_r [xbs_pkg::NT];
	xbs_pkg::xbs_req_t t_buf_r [xbs_pkg::NT];

	for (genvar gt = 0; gt < xbs_pkg::NT; gt++) begin : g_tgt
		logic win_any;
		logic [2:0] win_idx;
		logic [2:0] win_rank;
		logic [2:0] win_cnt;
		logic blocked;

		// A held memory bridge admits nothing to on-chip memory, so requests queued there simply stall.
		assign blocked = gt == xbs_pkg::T_ONCHIP_MEM && slave_bridge_reset_r; // [RQ12] [RQ13]

		always_comb begin
			win_any = 1'b0;
			win_idx = 3'h0;
			win_rank = 3'h7;
			win_cnt = 3'h0;
			for (int m = 0; m < xbs_pkg::NM; m++) begin
				if (i_m_req[m].stb && !o_m_rsp[m].ack && !o_m_rsp[m].err && m_target[m] == 3'(gt)
						&& bridge_hops(m, gt) != xbs_pkg::HOPS_NO_ROUTE && !blocked
						&& rank_at(m, gt) < win_rank) begin // [RQ4] [RQ6] [RQ2]
					win_any = 1'b1;
					win_idx = 3'(m);
					win_rank = rank_at(m, gt);
					win_cnt = 3'(BRIDGE_LAT * int'(bridge_hops(m, gt)));
				end
			end
		end

		// Requests stay with the master until granted, so losers just wait. [RQ16]
		always_ff @(posedge i_clk) begin
			if (i_rst) begin
				t_state_r[gt] <= XBS_IDLE;
				t_owner_r[gt] <= 3'h0;
				t_cnt_r[gt] <= 3'h0;
				t_buf_r[gt] <= '0;
			end else begin
				unique case (t_state_r[gt])
					XBS_IDLE: begin
						if (win_any) begin
							t_state_r[gt] <= XBS_CROSS; // [RQ3]
							t_owner_r[gt] <= win_idx;
							t_cnt_r[gt] <= win_cnt;
							t_buf_r[gt] <= i_m_req[win_idx]; // [RQ8]
						end
					end
					XBS_CROSS: begin
						if (t_cnt_r[gt] == 3'h0)
							t_state_r[gt] <= XBS_ISSUE; // [RQ8]
						else
							t_cnt_r[gt] <= t_cnt_r[gt] - 3'h1;
					end
					XBS_ISSUE: begin
						if (o_t_req[gt].stb && i_t_rsp[gt].ack)
							t_state_r[gt] <= XBS_DONE; // [RQ5]
					end
					XBS_DONE: begin
						t_state_r[gt] <= XBS_IDLE; // [RQ5]
					end
				endcase
			end
		end

		always_ff @(posedge i_clk) begin
			if (i_rst) begin
				o_t_req[gt] <= '0;
			end else if (t_state_r[gt] == XBS_CROSS && t_cnt_r[gt] == 3'h0) begin
				o_t_req[gt] <= t_buf_r[gt]; // [RQ2]
			end else if (o_t_req[gt].stb && i_t_rsp[gt].ack) begin
				o_t_req[gt].stb <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Master answers
	// ----------------------------------------
	for (genvar gm = 0; gm < xbs_pkg::NM; gm++) begin : g_mrsp
		logic done_hit;
		logic [31:0] done_dat;

		always_comb begin
			done_hit = 1'b0;
			done_dat = 32'h0000_0000;
			for (int t = 0; t < xbs_pkg::NT; t++) begin
				if (t_state_r[t] == XBS_ISSUE && t_owner_r[t] == 3'(gm) && o_t_req[t].stb && i_t_rsp[t].ack) begin
					done_hit = 1'b1;
					done_dat = i_t_rsp[t].dat;
				end
			end
		end

		// Unmapped or unroutable addresses end with an error so the master never hangs.
		always_ff @(posedge i_clk) begin
			if (i_rst) begin
				o_m_rsp[gm] <= '0;
			end else begin
				o_m_rsp[gm].ack <= done_hit; // [RQ5]
				o_m_rsp[gm].err <= i_m_req[gm].stb && m_unroutable[gm] && !o_m_rsp[gm].err;
				if (done_hit)
					o_m_rsp[gm].dat <= done_dat;
			end
		end
	end

endmodule

// *** verification/xbs_chk.sv ***
// Port-level assertions for the crossbar switch.
`timescale 1ns/1ps
module xbs_chk #(
	parameter int BRIDGE_LAT = 2
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire xbs_pkg::xbs_req_t i_m_req [xbs_pkg::NM],
	input wire xbs_pkg::xbs_rsp_t o_m_rsp [xbs_pkg::NM],
	input wire xbs_pkg::xbs_req_t o_t_req [xbs_pkg::NT],
	input wire xbs_pkg::xbs_rsp_t i_t_rsp [xbs_pkg::NT],
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [31:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	input wire logic [31:0] o_wb_dat,
	input wire logic o_wb_ack,
	input wire logic o_slave_bridge_reset
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	logic hit;
	assign hit = i_wb_cyc && i_wb_stb && i_wb_adr == xbs_pkg::BRIDGE_CONTROL_ADDR;
	a_wb_ack_resp: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
		else $error("register ack missing");
	a_wb_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("register ack too long");
	a_reset_value: assert property ($past(i_rst) |-> o_slave_bridge_reset)
		else $error("bridge reset bit not set by reset");
	a_write_takes: assert property (hit && o_wb_ack && i_wb_we && i_wb_sel[0] |=>
		o_slave_bridge_reset == $past(i_wb_dat[0]))
		else $error("bridge reset bit not written");
	a_rd_reserved: assert property (hit && o_wb_ack && !i_wb_we |-> o_wb_dat[31:1] == 31'h0)
		else $error("reserved bits not zero");
	for (genvar g = 0; g < xbs_pkg::NM; g++) begin : g_m
		a_mack_pulse: assert property (o_m_rsp[g].ack |=> !o_m_rsp[g].ack)
			else $error("master ack too long");
		a_mack_cause: assert property (o_m_rsp[g].ack || o_m_rsp[g].err |-> $past(i_m_req[g].stb))
			else $error("master answer without request");
	end
	for (genvar g = 0; g < xbs_pkg::NT; g++) begin : g_t
		a_tstb_hold: assert property (o_t_req[g].stb && !i_t_rsp[g].ack |=>
			o_t_req[g].stb && $stable(o_t_req[g].adr))
			else $error("target request dropped early");
		a_tdone_idle: assert property (i_t_rsp[g].ack |=> !o_t_req[g].stb)
			else $error("target request after ack");
	end
endmodule
bind xbs_crossbar xbs_chk #(.BRIDGE_LAT(BRIDGE_LAT)) u_chk (.i_clk(i_clk), .i_rst(i_rst),
	.i_m_req(i_m_req), .o_m_rsp(o_m_rsp), .o_t_req(o_t_req), .i_t_rsp(i_t_rsp),
	.i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
	.i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
	.o_slave_bridge_reset(o_slave_bridge_reset));

// *** verification/xbs_tgt_model.sv ***
// Models of the five target buses behind the crossbar.
`timescale 1ns/1ps
module xbs_tgt_model (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire xbs_pkg::xbs_req_t i_t_req [xbs_pkg::NT],
	output xbs_pkg::xbs_rsp_t o_t_rsp [xbs_pkg::NT]
);
	// Target t waits t cycles, so prompt and slow answers both occur.
	// Data marks the target, so a wrong route shows in the master's data.
	logic [2:0] cnt_r [xbs_pkg::NT];
	always_ff @(posedge i_clk) begin
		for (int t = 0; t < xbs_pkg::NT; t++) begin
			o_t_rsp[t].err <= 1'b0;
			if (i_rst || !i_t_req[t].stb || o_t_rsp[t].ack) begin
				cnt_r[t] <= 3'h0;
				o_t_rsp[t].ack <= 1'b0;
				o_t_rsp[t].dat <= i_t_req[t].adr;
			end else begin
				cnt_r[t] <= cnt_r[t] + 3'h1;
				o_t_rsp[t].ack <= cnt_r[t] == 3'(t);
				o_t_rsp[t].dat <= ~i_t_req[t].adr ^ 32'(t);
			end
		end
	end
endmodule

// *** verification/testbench.sv ***
// Self-checking bench for the crossbar switch.
`timescale 1ns/1ps
module testbench;
	localparam logic [31:0] BC = xbs_pkg::BRIDGE_CONTROL_ADDR;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	xbs_pkg::xbs_req_t m_req [xbs_pkg::NM];
	xbs_pkg::xbs_rsp_t m_rsp [xbs_pkg::NM];
	xbs_pkg::xbs_req_t t_req [xbs_pkg::NT];
	xbs_pkg::xbs_rsp_t t_rsp [xbs_pkg::NT];
	logic cyc, stb, we, ack, sbr;
	logic [3:0] sel;
	logic [31:0] adr, wd, rd, rdat;
	int miscompares = 0;
	int comparisons = 0;
	time tm [xbs_pkg::NM];
	xbs_crossbar DUT (.i_clk(i_clk), .i_rst(i_rst), .i_m_req(m_req), .o_m_rsp(m_rsp), .o_t_req(t_req),
		.i_t_rsp(t_rsp), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
		.i_wb_dat(wd), .o_wb_dat(rd), .o_wb_ack(ack), .o_slave_bridge_reset(sbr));
	xbs_tgt_model u_tgt (.i_clk(i_clk), .i_rst(i_rst), .i_t_req(t_req), .o_t_rsp(t_rsp));
	initial begin
		forever #2.5 i_clk = ~i_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge i_clk);
		{cyc, stb, we, adr, wd, sel} <= {2'b11, w, a, d, 4'hF};
		do @(posedge i_clk); while (ack !== 1'b1 && ++n < 50);
		rdat = rd;
		{cyc, stb} <= 2'b00;
		chk(32'(n < 50), 32'h1);
	endtask
	// A negative target index means the access has no route and must end in err.
	task automatic mx(input int i, input logic [31:0] a, input int k, output time t);
		int n = 0;
		@(posedge i_clk);
		m_req[i] <= '{1'b1, 1'b0, 4'hF, a, 32'h0};
		do @(posedge i_clk); while (m_rsp[i].ack !== 1'b1 && m_rsp[i].err !== 1'b1 && ++n < 300);
		t = $time;
		m_req[i].stb <= 1'b0;
		chk(32'(n < 300), 32'h1);
		if (k < 0) chk(32'(m_rsp[i].err), 32'h1);
		else chk(m_rsp[i].dat, ~a ^ 32'(k));
	endtask
	task automatic t_reg;
		wb(1'b0, BC, 32'h0);
		chk(rdat, 32'h1);
		wb(1'b0, BC + 32'h4, 32'h0);
		chk(rdat, 32'h0);
	endtask
	// The memory bridge holds host traffic until software releases it.
	task automatic t_block;
		fork
			mx(4, 32'h1000_0040, 0, tm[4]);
			begin
				repeat (40) @(posedge i_clk);
				chk(32'(t_req[0].stb), 32'h0);
				wb(1'b1, BC, 32'h0);
			end
		join
		wb(1'b0, BC, 32'h0);
		chk(rdat, 32'h0);
		chk(32'(sbr), 32'h0);
	endtask
	task automatic t_route;
		logic [31:0] ta [5] = '{32'h1000_0010, 32'h8000_0010, 32'h4000_0010, 32'h5400_0010, 32'h6000_0010};
		for (int k = 0; k < 5; k++) mx(2, ta[k], k, tm[2]);
		mx(4, 32'h9000_0020, 1, tm[4]);
		mx(1, 32'h4000_0010, -1, tm[1]);
		mx(0, 32'h1000_0010, -1, tm[0]);
	endtask
	task automatic t_arb;
		fork
			mx(2, 32'h4000_0030, 2, tm[2]);
			mx(3, 32'h4100_0030, 2, tm[3]);
		join
		chk(32'(tm[2] < tm[3]), 32'h1);
		fork
			mx(3, 32'h4700_0000, 2, tm[3]);
			begin
				@(posedge i_clk);
				mx(2, 32'h4200_0000, 2, tm[2]);
			end
		join
		chk(32'(tm[3] < tm[2]), 32'h1);
		fork
			mx(0, 32'h8000_0100, 1, tm[0]);
			mx(1, 32'h8000_0200, 1, tm[1]);
		join
		chk(32'(tm[0] < tm[1]), 32'h1);
	endtask
	task automatic t_par;
		time ts = $time;
		fork
			mx(0, 32'h6000_0020, 4, tm[0]);
			mx(1, 32'h8000_0040, 1, tm[1]);
			mx(4, 32'h1000_0080, 0, tm[4]);
			mx(2, 32'h5400_0020, 3, tm[2]);
			mx(3, 32'h4000_0020, 2, tm[3]);
		join
		for (int i = 0; i < 5; i++) chk(32'(tm[i] - ts <= 100), 32'h1);
	endtask
	task automatic results;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		for (int i = 0; i < 5; i++) m_req[i] <= '0;
		{cyc, stb, we, adr, wd, sel} <= '0;
		repeat (4) @(posedge i_clk);
		i_rst <= 1'b0;
		t_reg;
		t_block;
		t_route;
		t_arb;
		t_par;
		results;
	end
	initial begin
		#50us;
		miscompares++;
		results;
	end
endmodule
